// File: verilog/sad_decode.sv
// file: top of the system address decoder with boot defaults
`timescale 1ns/1ps
`default_nettype none
module sad_decode #(
   parameter sad_pkg::sad_variant_t VARIANT = '{sram_64k: 1'b1, flash_sel: 2'h0, has_xbus: 1'b1}
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // power, software clock control and flash wait state
   input  wire logic             power_good,
   input  wire logic             sw_mult0_en,
   input  wire logic             sw_mult1_en,
   input  wire logic             flash_one_ws,
   // erase command, fuse and user page writes
   input  wire logic             chip_erase,
   input  wire logic             fuse_wr,
   input  wire logic [31:0]      fuse_wdata,
   input  wire logic             upage_wr,
   input  wire logic [31:0]      upage_wdata,
   // master request
   input  wire sad_pkg::sad_req_t req,
   // routing, answer, chip reset, boot state, fuses and user page
   output var sad_pkg::sad_tgt_t tgt_ff,
   output logic                  resp_ok_ff,
   output logic                  resp_err_ff,
   output logic                  sys_rst_n_ff,
   output logic [31:0]           boot_addr_ff,
   output var sad_pkg::sad_clk_t clk_state_ff,
   output logic [31:0]           fuses_ff,
   output logic [31:0]           user_page_ff
);
   // ***************************************************************
   // power-good synchroniser and system reset
   // ***************************************************************
   logic [1:0] pg_sync_ff;
   logic       pg_s;

   // power_good comes from the analog cell, two flops before any use
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pg_sync_ff <= 2'h0;
      end else begin
         pg_sync_ff <= {pg_sync_ff[0], power_good};
      end
   end
   assign pg_s = pg_sync_ff[1];

   // chip logic stays in reset while the supply is unstable
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sys_rst_n_ff <= 1'b0;
      end else begin
         sys_rst_n_ff <= pg_s;
      end
   end

   // ***************************************************************
   // boot clock state and reset vector
   // ***************************************************************
   // multipliers may only start once the chip is out of reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clk_state_ff <= '{rc_selected: 1'b1, mult0_en: 1'b0, mult1_en: 1'b0,
                           all_ungated: 1'b1, div_bypass: 1'b1};
      end else if (!sys_rst_n_ff) begin
         clk_state_ff <= '{rc_selected: 1'b1, mult0_en: 1'b0, mult1_en: 1'b0,
                           all_ungated: 1'b1, div_bypass: 1'b1};
      end else begin
         clk_state_ff.mult0_en <= sw_mult0_en;
         clk_state_ff.mult1_en <= sw_mult1_en;
      end
   end

   // fetch vector is a constant, no boot remap exists
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         boot_addr_ff <= sad_pkg::RESET_FETCH;
      end else begin
         boot_addr_ff <= sad_pkg::RESET_FETCH;
      end
   end

   // ***************************************************************
   // region decode
   // ***************************************************************
   localparam int NREG = 9;
   logic [31:0] bases [NREG];
   logic [31:0] sizes [NREG];
   logic        pres  [NREG];
   logic [NREG-1:0] hits;

   // variant flash size lookup
   function automatic logic [31:0] flash_size(input logic [1:0] sel);
      unique case (sel)
         2'h0:    flash_size = sad_pkg::SZ_512K;
         2'h1:    flash_size = sad_pkg::SZ_256K;
         default: flash_size = sad_pkg::SZ_128K;
      endcase
   endfunction

   // fixed window table; bases never depend on phase
   assign bases[0] = sad_pkg::SRAM_BASE;
   assign sizes[0] = VARIANT.sram_64k ? sad_pkg::SZ_64K : sad_pkg::SZ_32K;
   assign pres[0]  = 1'b1;
   assign bases[1] = sad_pkg::FLASH_BASE;
   assign sizes[1] = flash_size(VARIANT.flash_sel);
   assign pres[1]  = 1'b1;
   assign bases[2] = sad_pkg::XCS0_BASE;
   assign bases[3] = sad_pkg::XCS2_BASE;
   assign bases[4] = sad_pkg::XCS3_BASE;
   assign sizes[2] = sad_pkg::SZ_16M;
   assign sizes[3] = sad_pkg::SZ_16M;
   assign sizes[4] = sad_pkg::SZ_16M;
   assign pres[2]  = VARIANT.has_xbus;
   assign pres[3]  = VARIANT.has_xbus;
   assign pres[4]  = VARIANT.has_xbus;
   assign bases[5] = sad_pkg::XSHR_BASE;
   assign sizes[5] = sad_pkg::SZ_128M;
   assign pres[5]  = VARIANT.has_xbus;
   assign bases[6] = sad_pkg::USB_BASE;
   assign sizes[6] = sad_pkg::SZ_64K;
   assign pres[6]  = 1'b1;
   assign bases[7] = sad_pkg::BRGA_BASE;
   assign bases[8] = sad_pkg::BRGB_BASE;
   assign sizes[7] = sad_pkg::SZ_64K;
   assign sizes[8] = sad_pkg::SZ_64K;
   assign pres[7]  = 1'b1;
   assign pres[8]  = 1'b1;

   // one comparator per window
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_win
         sad_region_match u_match (
            .addr    (req.addr),
            .base    (bases[gi]),
            .size    (sizes[gi]),
            .present (pres[gi]),
            .hit     (hits[gi])
         );
      end
   endgenerate

   // windows are disjoint so at most one hit; raw address, no segmentation
   sad_pkg::sad_tgt_t nxt_tgt;
   always_comb begin
      nxt_tgt = sad_pkg::TGT_NONE;
      for (int i = 0; i < NREG; i++) begin
         if (hits[i]) begin
            nxt_tgt = sad_pkg::sad_tgt_t'(4'(i + 1));
         end
      end
   end

   // ***************************************************************
   // access timing and answer
   // ***************************************************************
   logic flash_start;
   logic flash_done;
   logic busy_ff;

   assign flash_start = sys_rst_n_ff && (req.valid || busy_ff) && (nxt_tgt == sad_pkg::TGT_FLASH);

   sad_flash_rd u_flash (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .start   (flash_start),
      .addr    (req.addr),
      .one_ws  (flash_one_ws),
      .done    (flash_done)
   );

   // flash access with a wait state keeps the master stalled one cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= flash_start && !flash_done;
      end
   end

   // registered answer: ok, or error for unmapped or absent regions
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tgt_ff      <= sad_pkg::TGT_NONE;
         resp_ok_ff  <= 1'b0;
         resp_err_ff <= 1'b0;
      end else begin
         tgt_ff      <= (req.valid && sys_rst_n_ff) ? nxt_tgt : sad_pkg::TGT_NONE;
         resp_ok_ff  <= 1'b0;
         resp_err_ff <= 1'b0;
         if (sys_rst_n_ff && (req.valid || busy_ff)) begin
            if (nxt_tgt == sad_pkg::TGT_NONE) begin
               resp_err_ff <= 1'b1;
            end else if (nxt_tgt == sad_pkg::TGT_FLASH) begin
               resp_ok_ff  <= flash_done;
            end else begin
               resp_ok_ff  <= 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // fuses and user page
   // ***************************************************************
   // erase wins over a write in the same cycle; user page is untouched
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fuses_ff     <= sad_pkg::FUSE_ERASED;
         user_page_ff <= 32'h0000_0000;
      end else begin
         if (chip_erase) begin
            fuses_ff <= sad_pkg::FUSE_ERASED;
         end else if (fuse_wr) begin
            fuses_ff <= fuse_wdata;
         end
         if (upage_wr) begin
            user_page_ff <= upage_wdata;
         end
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   a_sram_single: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'h0000) |=> resp_ok_ff)
      else $error("sram access not single cycle");
   a_unmapped_err: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:28] == 4'h4) |=> resp_err_ff)
      else $error("unmapped access without error");
   a_flash_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'h8000) |=> tgt_ff == sad_pkg::TGT_FLASH)
      else $error("flash base misrouted");
   a_bridge_b: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'hffff) |=> tgt_ff == sad_pkg::TGT_BRGB)
      else $error("bridge b misrouted");
   a_reset_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !pg_s |=> !sys_rst_n_ff)
      else $error("reset released without power good");
   a_mult_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !sys_rst_n_ff |=> !clk_state_ff.mult0_en && !clk_state_ff.mult1_en)
      else $error("multiplier on during reset");
   a_boot_vec: assert property (@(posedge clk_sys) disable iff (!arst_n)
      boot_addr_ff == sad_pkg::RESET_FETCH && clk_state_ff.rc_selected)
      else $error("boot vector or source wrong");
   a_erase_fuse: assert property (@(posedge clk_sys) disable iff (!arst_n)
      chip_erase && !upage_wr |=> fuses_ff == sad_pkg::FUSE_ERASED
         && user_page_ff == $past(user_page_ff))
      else $error("erase fuse or user page wrong");
   a_ws_flash: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!flash_one_ws && flash_start) |=> resp_ok_ff)
      else $error("zero wait flash delayed");

   // ***************************************************************
   // routing of the remaining windows, then hole, answer, reset and boot clock checks and covers
   // ***************************************************************
   // sram window must also name its target, not only answer in time
   a_sram_tgt: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'h0000) |=> tgt_ff == sad_pkg::TGT_SRAM)
      else $error("sram base misrouted");

   // first external select window
   a_xcs0_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:24] == 8'hc0) |=> tgt_ff == sad_pkg::TGT_XCS0)
      else $error("external select zero misrouted");

   // second external select window
   a_xcs2_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:24] == 8'hc8) |=> tgt_ff == sad_pkg::TGT_XCS2)
      else $error("external select two misrouted");

   // third external select window
   a_xcs3_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:24] == 8'hcc) |=> tgt_ff == sad_pkg::TGT_XCS3)
      else $error("external select three misrouted");

   // shared select covers the whole 128M, not just its first page
   a_xshr_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:27] == 5'h1a) |=> tgt_ff == sad_pkg::TGT_XSHR)
      else $error("shared select misrouted");

   // usb configuration space
   a_usb_hit: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'he000) |=> tgt_ff == sad_pkg::TGT_USB)
      else $error("usb window misrouted");

   // first peripheral bridge
   a_bridge_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:16] == 16'hfffe) |=> tgt_ff == sad_pkg::TGT_BRGA)
      else $error("bridge a misrouted");

   // a hole low in the map must not alias onto sram
   a_hole_err: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sys_rst_n_ff && req.valid && req.addr[31:28] == 4'h1) |=> resp_err_ff)
      else $error("low hole without error");

   // never both kinds of answer in the same cycle
   a_one_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !(resp_ok_ff && resp_err_ff))
      else $error("ok and error together");

   // nothing answers while the chip is held in reset
   a_rst_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !sys_rst_n_ff |=> !resp_ok_ff && !resp_err_ff)
      else $error("answer during chip reset");

   // source, gating and dividers never leave their boot state here
   a_clk_boot: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clk_state_ff.rc_selected && clk_state_ff.all_ungated && clk_state_ff.div_bypass)
      else $error("boot clock state lost");

   // covers for the main scenarios
   c_flash_ws: cover property (@(posedge clk_sys) disable iff (!arst_n) busy_ff ##1 resp_ok_ff);
   c_burst: cover property (@(posedge clk_sys) disable iff (!arst_n) flash_one_ws && resp_ok_ff ##1 resp_ok_ff);
   c_erase: cover property (@(posedge clk_sys) disable iff (!arst_n) chip_erase && fuse_wr);
   c_err: cover property (@(posedge clk_sys) disable iff (!arst_n) resp_err_ff);
   c_boot: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(sys_rst_n_ff));
endmodule
`default_nettype wire

// File: verilog/sad_pkg.sv
// package: region map, boot defaults and timing constants for the system address decoder
package sad_pkg;

   // ***************************************************************
   // region map
   // ***************************************************************
   localparam logic [31:0] SRAM_BASE   = 32'h0000_0000;
   localparam logic [31:0] FLASH_BASE  = 32'h8000_0000;
   localparam logic [31:0] XCS0_BASE   = 32'hc000_0000;
   localparam logic [31:0] XCS2_BASE   = 32'hc800_0000;
   localparam logic [31:0] XCS3_BASE   = 32'hcc00_0000;
   localparam logic [31:0] XSHR_BASE   = 32'hd000_0000;
   localparam logic [31:0] USB_BASE    = 32'he000_0000;
   localparam logic [31:0] BRGA_BASE   = 32'hfffe_0000;
   localparam logic [31:0] BRGB_BASE   = 32'hffff_0000;
   localparam logic [31:0] SZ_16M      = 32'h0100_0000;
   localparam logic [31:0] SZ_128M     = 32'h0800_0000;
   localparam logic [31:0] SZ_64K      = 32'h0001_0000;
   localparam logic [31:0] SZ_32K      = 32'h0000_8000;
   localparam logic [31:0] SZ_512K     = 32'h0008_0000;
   localparam logic [31:0] SZ_256K     = 32'h0004_0000;
   localparam logic [31:0] SZ_128K     = 32'h0002_0000;
   localparam logic [31:0] RESET_FETCH = 32'h8000_0000;

   // ***************************************************************
   // flash timing and fuses
   // ***************************************************************
   localparam int          FLASH_0WS_MHZ = 33;
   localparam int          FLASH_1WS_MHZ = 66;
   localparam logic [31:0] FUSE_ERASED   = 32'hffff_ffff;
   localparam logic [1:0]  SYNC_DONE     = 2'h3;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [3:0] {
      TGT_NONE  = 4'h0,
      TGT_SRAM  = 4'h1,
      TGT_FLASH = 4'h2,
      TGT_XCS0  = 4'h3,
      TGT_XCS2  = 4'h4,
      TGT_XCS3  = 4'h5,
      TGT_XSHR  = 4'h6,
      TGT_USB   = 4'h7,
      TGT_BRGA  = 4'h8,
      TGT_BRGB  = 4'h9
   } sad_tgt_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
   } sad_req_t;

   typedef struct packed {
      logic        sram_64k;
      logic [1:0]  flash_sel;   // 0: 512K, 1: 256K, 2: 128K
      logic        has_xbus;
   } sad_variant_t;

   // power-up clock state seen by the rest of the chip
   typedef struct packed {
      logic        rc_selected;
      logic        mult0_en;
      logic        mult1_en;
      logic        all_ungated;
      logic        div_bypass;
   } sad_clk_t;

endpackage

// File: verilog/sad_region_match.sv
// file: one fixed base/size window comparator
`timescale 1ns/1ps
`default_nettype none
module sad_region_match (
   // address and window
   input  wire logic [31:0] addr,
   input  wire logic [31:0] base,
   input  wire logic [31:0] size,
   input  wire logic        present,
   // result
   output logic             hit
);
   // size is a power of two so the base compare is a mask of the upper bits
   assign hit = present && (((addr ^ base) & ~(size - 32'h0000_0001)) == 32'h0000_0000);
endmodule
`default_nettype wire

// File: verilog/sad_flash_rd.sv
// file: flash read timing with wait states and sequential pipelining
`timescale 1ns/1ps
`default_nettype none
module sad_flash_rd (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // access request
   input  wire logic        start,
   input  wire logic [31:0] addr,
   input  wire logic        one_ws,
   // completion
   output logic             done
);
   logic [31:0] last_addr_ff;
   logic        last_ok_ff;
   logic        wait_ff;
   logic        seq;

   // sequential word continues the prefetched line
   assign seq = last_ok_ff && (addr == (last_addr_ff + 32'h0000_0004));

   // wait state held only for non-sequential first accesses
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= start && one_ws && !seq && !wait_ff;
      end
   end

   // address history for the pipeline, lost on any idle gap
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         last_addr_ff <= 32'h0000_0000;
         last_ok_ff   <= 1'b0;
      end else if (start) begin
         last_addr_ff <= addr;
         last_ok_ff   <= 1'b1;
      end else begin
         last_ok_ff   <= 1'b0;
      end
   end

   // zero wait: same cycle; one wait: second cycle unless sequential
   assign done = start && (!one_ws || seq || wait_ff);
endmodule
`default_nettype wire

// File: tb/sad_cpu_model.sv
// partner model: a bus master that issues single-word accesses to the decoder
`timescale 1ns/1ps
`default_nettype none
module sad_cpu_model (
   // clock
   input  wire logic               clk_sys,
   // request toward the decoder
   output var sad_pkg::sad_req_t   req,
   // answer from the decoder
   input  wire logic               resp_ok_ff,
   input  wire logic               resp_err_ff,
   input  wire sad_pkg::sad_tgt_t  tgt_ff
);
   // ***************************************************************
   // idle state
   // ***************************************************************
   initial begin
      req = '{valid: 1'b0, write: 1'b0, addr: 32'hffff_ffff};
   end

   // ***************************************************************
   // one access
   // ***************************************************************
   // entered at a falling edge; the request is held until the answer shows or eight cycles pass,
   // and keep leaves valid up so the next call forms a back-to-back burst
   task automatic access(input logic [31:0] a, input logic wr, input logic keep,
                         output logic ok, output logic err, output sad_pkg::sad_tgt_t tg, output int lat);
      lat = 0;
      ok  = 1'b0;
      err = 1'b0;
      tg  = sad_pkg::TGT_NONE;
      req = '{valid: 1'b1, write: wr, addr: a};
      for (int n = 1; n <= 8 && lat == 0; n++) begin
         @(negedge clk_sys);
         if (resp_ok_ff === 1'b1 || resp_err_ff === 1'b1) begin
            lat = n;
            ok  = resp_ok_ff;
            err = resp_err_ff;
            tg  = tgt_ff;
         end
      end
      // a released bus shows the inverse address, never the stale one
      if (!keep) begin
         req = '{valid: 1'b0, write: ~wr, addr: ~a};
      end
   endtask
endmodule
`default_nettype wire

// File: tb/test_sad_decode.sv
// testbench: region routing, boot defaults, flash timing and fuse erase of the decoder
`timescale 1ns/1ps
`default_nettype none
module test_sad_decode;
   typedef struct {
      logic [31:0]       addr;
      sad_pkg::sad_tgt_t tgt;
      logic              err;
   } sad_row_t;

   logic               clk_sys, arst_n, power_good, sw_mult0_en, sw_mult1_en, flash_one_ws;
   logic               chip_erase, fuse_wr, upage_wr, resp_ok_ff, resp_err_ff, sys_rst_n_ff;
   logic [31:0]        fuse_wdata, upage_wdata, boot_addr_ff, fuses_ff, user_page_ff;
   sad_pkg::sad_req_t  req;
   sad_pkg::sad_tgt_t  tgt_ff;
   sad_pkg::sad_clk_t  clk_state_ff;
   int                 n_errors = 0;
   int                 n_checks = 0;
   sad_row_t           rows [21];

   sad_decode u_sad_decode (
      .clk_sys(clk_sys), .arst_n(arst_n), .power_good(power_good), .sw_mult0_en(sw_mult0_en),
      .sw_mult1_en(sw_mult1_en), .flash_one_ws(flash_one_ws), .chip_erase(chip_erase), .fuse_wr(fuse_wr),
      .fuse_wdata(fuse_wdata), .upage_wr(upage_wr), .upage_wdata(upage_wdata), .req(req), .tgt_ff(tgt_ff),
      .resp_ok_ff(resp_ok_ff), .resp_err_ff(resp_err_ff), .sys_rst_n_ff(sys_rst_n_ff),
      .boot_addr_ff(boot_addr_ff), .clk_state_ff(clk_state_ff), .fuses_ff(fuses_ff),
      .user_page_ff(user_page_ff)
   );

   sad_cpu_model u_sad_cpu_model (
      .clk_sys(clk_sys), .req(req), .resp_ok_ff(resp_ok_ff), .resp_err_ff(resp_err_ff), .tgt_ff(tgt_ff)
   );

   // ***************************************************************
   // compare and report
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_tgt(input string nm, input sad_pkg::sad_tgt_t exp, input sad_pkg::sad_tgt_t got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one access through the master model, all four results compared
   task automatic go(input logic [31:0] a, input logic wr, input logic keep, input sad_pkg::sad_tgt_t et,
                     input logic ee, input int el);
      logic              ok, err;
      sad_pkg::sad_tgt_t tg;
      int                lat;
      u_sad_cpu_model.access(a, wr, keep, ok, err, tg, lat);
      chk_tgt("target", et, tg);
      chk("error", {31'h0, ee}, {31'h0, err});
      chk("done", {31'h0, !ee && el != 0}, {31'h0, ok});
      chk("latency", el, lat);
      // a missing answer means the run cannot go on sensibly
      if (lat == 0 && el != 0) begin
         give_verdict();
      end
   endtask

   // bounded wait for the chip reset to lift
   task automatic wait_rst();
      for (int n = 0; n < 8 && sys_rst_n_ff !== 1'b1; n++) begin
         @(negedge clk_sys);
      end
      if (sys_rst_n_ff !== 1'b1) begin
         n_errors++;
         $display("ERROR sys_rst_n_ff expected 1 seen %b", sys_rst_n_ff);
         give_verdict();
      end
   endtask

   task automatic pulse_reset(input logic pg);
      arst_n     = 1'b0;
      power_good = pg;
      repeat (2) @(negedge clk_sys);
      chk("rst_hold", 32'h0, {31'h0, sys_rst_n_ff});
      chk("clk_state", 32'h13, {27'h0, clk_state_ff});
      chk("boot_addr", 32'h8000_0000, boot_addr_ff);
      arst_n = 1'b1;
   endtask

   // ***************************************************************
   // clock
   // ***************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      sw_mult0_en  = 1'b0;
      sw_mult1_en  = 1'b0;
      flash_one_ws = 1'b0;
      chip_erase   = 1'b0;
      fuse_wr      = 1'b0;
      upage_wr     = 1'b0;
      fuse_wdata   = 32'h0;
      upage_wdata  = 32'h0;
      // window edges: first or last word inside, first word past the end for sram, flash, xcs0, xshr and usb
      rows = '{'{32'h0000_0010, sad_pkg::TGT_SRAM, 1'b0}, '{32'h0000_fffc, sad_pkg::TGT_SRAM, 1'b0},
               '{32'h0001_0000, sad_pkg::TGT_NONE, 1'b1}, '{32'h8000_0000, sad_pkg::TGT_FLASH, 1'b0},
               '{32'h8007_fffc, sad_pkg::TGT_FLASH, 1'b0}, '{32'h8008_0000, sad_pkg::TGT_NONE, 1'b1},
               '{32'hc000_0000, sad_pkg::TGT_XCS0, 1'b0}, '{32'hc0ff_fffc, sad_pkg::TGT_XCS0, 1'b0},
               '{32'hc100_0000, sad_pkg::TGT_NONE, 1'b1}, '{32'hc800_0000, sad_pkg::TGT_XCS2, 1'b0},
               '{32'hcc00_0000, sad_pkg::TGT_XCS3, 1'b0}, '{32'hccff_fffc, sad_pkg::TGT_XCS3, 1'b0},
               '{32'hd000_0000, sad_pkg::TGT_XSHR, 1'b0}, '{32'hd7ff_fffc, sad_pkg::TGT_XSHR, 1'b0},
               '{32'hd800_0000, sad_pkg::TGT_NONE, 1'b1}, '{32'he000_0000, sad_pkg::TGT_USB, 1'b0},
               '{32'he000_fffc, sad_pkg::TGT_USB, 1'b0}, '{32'he001_0000, sad_pkg::TGT_NONE, 1'b1},
               '{32'hfffe_0000, sad_pkg::TGT_BRGA, 1'b0}, '{32'hffff_fffc, sad_pkg::TGT_BRGB, 1'b0},
               '{32'h4000_0000, sad_pkg::TGT_NONE, 1'b1}};
      pulse_reset(1'b1);
      wait_rst();
      chk("fuses_rst", 32'hffff_ffff, fuses_ff);
      // table of regions, back to back, reads and writes alternating
      for (int i = 0; i < 21; i++) begin
         go(rows[i].addr, i[0], i < 20, rows[i].tgt, rows[i].err, 1);
      end
      // multipliers stay off until software raises its enable
      repeat (3) @(negedge clk_sys);
      chk("mult_idle", 32'h13, {27'h0, clk_state_ff});
      sw_mult0_en = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("mult0_on", 32'h1b, {27'h0, clk_state_ff});
      sw_mult0_en = 1'b0;
      sw_mult1_en = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("mult1_on", 32'h17, {27'h0, clk_state_ff});
      sw_mult1_en = 1'b0;
      // one wait state set before the faster clock is used
      flash_one_ws = 1'b1;
      go(32'h8000_0100, 1'b0, 1'b1, sad_pkg::TGT_FLASH, 1'b0, 2);
      go(32'h8000_0104, 1'b0, 1'b1, sad_pkg::TGT_FLASH, 1'b0, 1);
      go(32'h8000_0108, 1'b0, 1'b1, sad_pkg::TGT_FLASH, 1'b0, 1);
      go(32'h0000_0200, 1'b1, 1'b1, sad_pkg::TGT_SRAM, 1'b0, 1);
      go(32'h8000_0110, 1'b0, 1'b0, sad_pkg::TGT_FLASH, 1'b0, 2);
      flash_one_ws = 1'b0;
      go(32'h8000_0200, 1'b0, 1'b0, sad_pkg::TGT_FLASH, 1'b0, 1);
      // fuse and user page writes, then an erase racing a fuse write
      fuse_wr     = 1'b1;
      fuse_wdata  = 32'h1234_5678;
      upage_wr    = 1'b1;
      upage_wdata = 32'ha5a5_0f0f;
      @(negedge clk_sys);
      fuse_wr    = 1'b0;
      upage_wr   = 1'b0;
      chk("fuses_wr", 32'h1234_5678, fuses_ff);
      chip_erase = 1'b1;
      fuse_wr    = 1'b1;
      fuse_wdata = 32'h0;
      @(negedge clk_sys);
      chip_erase = 1'b0;
      fuse_wr    = 1'b0;
      chk("fuses_erase", 32'hffff_ffff, fuses_ff);
      chk("upage_keep", 32'ha5a5_0f0f, user_page_ff);
      // second reset with unstable supply: chip stays in reset, requests ignored
      pulse_reset(1'b0);
      repeat (6) @(negedge clk_sys);
      chk("rst_unstable", 32'h0, {31'h0, sys_rst_n_ff});
      go(32'h0000_0010, 1'b0, 1'b0, sad_pkg::TGT_NONE, 1'b0, 0);
      power_good = 1'b1;
      wait_rst();
      chk("clk_after", 32'h13, {27'h0, clk_state_ff});
      go(32'h8000_0000, 1'b0, 1'b0, sad_pkg::TGT_FLASH, 1'b0, 1);
      give_verdict();
   end
endmodule
`default_nettype wire
